// ===== src/haptic_pkg.sv
// constants, types and effect table for the haptic effect pwm controller
// assumes a single 200 mhz clock domain; scl and sda arrive as raw pin levels
package haptic_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h10;
  localparam int CLK_HZ = 200_000_000;
  localparam int VIB_FREQ_HZ = 200;
  localparam int HALF_PERIOD_CYCLES = CLK_HZ / (2 * VIB_FREQ_HZ);
  localparam int STRETCH_TIMEOUT_US = 1000;
  localparam int STRETCH_TIMEOUT_CYCLES = STRETCH_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int PWM_BITS = 10;
  localparam int TIMER_BITS = 24;
  localparam logic [PWM_BITS-1:0] DUTY_MID = 10'h200;
  localparam logic [7:0] CMD_PLAY = 8'h01;
  localparam logic [7:0] CMD_ABORT = 8'h02;
  localparam logic [7:0] CMD_REVISION = 8'h03;
  localparam logic [7:0] LAST_EFFECT = 8'h0D;
  localparam logic [15:0] REVISION_DEFAULT = 16'h0001;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] FULL_BYTE = 4'h8;
  localparam logic [1:0] CMD_LAST_BYTE = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK = 3'b011,
    ST_STRETCH = 3'b010,
    ST_SEND = 3'b110,
    ST_MACK = 3'b111,
    ST_WAITSTOP = 3'b101
  } i2c_state_e_t;

  typedef struct packed {
    logic [2:0] sclSync;
    logic [2:0] sdaSync;
    logic sclF;
    logic sdaF;
    i2c_state_e_t state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [1:0] byteIdx;
    logic isRead;
    logic txIdx;
    logic [7:0] cmd0;
    logic [7:0] cmd1;
    logic cmdValid;
    logic [TIMER_BITS-1:0] tmo;
    logic sclOe;
    logic sdaOe;
    logic drivePos;
    logic driveNeg;
  } i2c_state_t;

  typedef struct packed {
    logic [PWM_BITS-1:0] amp;
    logic [PWM_BITS-1:0] decay;
    logic [7:0] halves;
  } effect_t;

  typedef struct packed {
    logic [PWM_BITS-1:0] carrier;
    logic [TIMER_BITS-1:0] halfCnt;
    logic phase;
    logic [PWM_BITS-1:0] amp;
    logic [PWM_BITS-1:0] decay;
    logic [7:0] halvesLeft;
    logic playing;
    logic pwm;
    logic taken;
  } player_state_t;

  // amplitude, decay per half period, length in half periods
  function automatic effect_t effect_lut(input logic [3:0] idx);
    unique case (idx)
      4'h0: effect_lut = '{10'h3FF, 10'h000, 8'h0C};
      4'h1: effect_lut = '{10'h200, 10'h000, 8'h0C};
      4'h2: effect_lut = '{10'h3FF, 10'h040, 8'h10};
      4'h3: effect_lut = '{10'h200, 10'h020, 8'h10};
      4'h4: effect_lut = '{10'h3FF, 10'h000, 8'h28};
      4'h5: effect_lut = '{10'h200, 10'h000, 8'h28};
      4'h6: effect_lut = '{10'h3FF, 10'h020, 8'h20};
      4'h7: effect_lut = '{10'h200, 10'h010, 8'h20};
      4'h8: effect_lut = '{10'h300, 10'h000, 8'h06};
      4'h9: effect_lut = '{10'h180, 10'h000, 8'h06};
      4'hA: effect_lut = '{10'h3FF, 10'h008, 8'h50};
      4'hB: effect_lut = '{10'h200, 10'h004, 8'h50};
      4'hC: effect_lut = '{10'h3FF, 10'h080, 8'h08};
      default: effect_lut = '{10'h200, 10'h040, 8'h08};
    endcase
  endfunction : effect_lut
endpackage : haptic_pkg

// ===== src/effect_player.sv
// effect sequencer and 10-bit pwm modulator
// assumes command fields are stable while cmdValid is high, same clock domain
module effect_player import haptic_pkg::*; #(
  parameter int HALF_CYCLES = HALF_PERIOD_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cmdValid,
  input wire logic [7:0] cmd0,
  input wire logic [7:0] cmd1,
  output logic cmdTaken,
  output logic playing,
  output logic pwm
);
  localparam logic [TIMER_BITS-1:0] HALF_LAST = TIMER_BITS'(HALF_CYCLES - 1);

  player_state_t r;
  player_state_t n;
  effect_t eff;

  // square-wave vibration around mid duty, depth set by envelope
  function automatic logic [PWM_BITS-1:0] duty_of(input player_state_t s);
    logic [PWM_BITS-1:0] half;
    half = s.amp >> 1;
    duty_of = s.phase ? DUTY_MID + half : DUTY_MID - half;
  endfunction : duty_of

  always_comb begin
    n = r;
    eff = effect_lut(cmd1[3:0]);
    n.taken = 1'b0;
    n.carrier = r.carrier + 10'h001;
    n.pwm = r.playing && (r.carrier < duty_of(r));
    if (r.playing) begin
      if (r.halfCnt == HALF_LAST) begin
        n.halfCnt = '0;
        n.phase = ~r.phase;
        n.amp = (r.amp > r.decay) ? r.amp - r.decay : '0;
        n.halvesLeft = r.halvesLeft - 8'h01;
        if (r.halvesLeft == 8'h01) begin
          n.playing = 1'b0;
        end
      end else begin
        n.halfCnt = r.halfCnt + 1'b1;
      end
    end
    // commands land only on a carrier boundary to avoid runt pulses
    if (cmdValid && !r.taken && r.carrier == '0) begin
      n.taken = 1'b1;
      if (cmd0 == CMD_PLAY && cmd1 <= LAST_EFFECT) begin
        n.playing = 1'b1;
        n.halfCnt = '0;
        n.phase = 1'b1;
        n.amp = eff.amp;
        n.decay = eff.decay;
        n.halvesLeft = eff.halves;
      end else if (cmd0 == CMD_ABORT) begin
        n.playing = 1'b0;
        n.pwm = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign cmdTaken = r.taken;
  assign playing = r.playing;
  assign pwm = r.pwm;
endmodule : effect_player

// ===== src/haptic_effect_pwm_controller.sv
// i2c slave front end and drive-pin stage of the haptic controller
// assumes scl and sda are open-drain wires with pull-ups resolved outside
module haptic_effect_pwm_controller import haptic_pkg::*; #(
  parameter int HALF_CYCLES = HALF_PERIOD_CYCLES,
  parameter int STRETCH_TIMEOUT = STRETCH_TIMEOUT_CYCLES,
  parameter logic [15:0] REVISION = REVISION_DEFAULT
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic driveOutPos,
  output logic driveOutNeg
);
  localparam logic [TIMER_BITS-1:0] TMO_LAST = TIMER_BITS'(STRETCH_TIMEOUT - 1);

  i2c_state_t r;
  i2c_state_t n;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic [7:0] txNext;
  logic cmdTaken;
  logic playing;
  logic pwm;

  // revision high byte first, then low byte, repeating
  function automatic logic [7:0] rev_byte(input logic idx);
    rev_byte = idx ? REVISION[7:0] : REVISION[15:8];
  endfunction : rev_byte

  effect_player #(
    .HALF_CYCLES(HALF_CYCLES)
  ) player (
    .clock(clock),
    .rstn(rstn),
    .cmdValid(r.cmdValid),
    .cmd0(r.cmd0),
    .cmd1(r.cmd1),
    .cmdTaken(cmdTaken),
    .playing(playing),
    .pwm(pwm)
  );

  always_comb begin
    n = r;
    txNext = rev_byte(r.txIdx);
    n.sclSync = {r.sclSync[1:0], sclIn};
    n.sdaSync = {r.sdaSync[1:0], sdaIn};
    if (r.sclSync[1] == r.sclSync[2]) begin
      n.sclF = r.sclSync[2];
    end
    if (r.sdaSync[1] == r.sdaSync[2]) begin
      n.sdaF = r.sdaSync[2];
    end
    sclRise = !r.sclF && n.sclF;
    sclFall = r.sclF && !n.sclF;
    startCond = r.sclF && n.sclF && r.sdaF && !n.sdaF;
    stopCond = r.sclF && n.sclF && !r.sdaF && n.sdaF;
    if (r.cmdValid && cmdTaken) begin
      n.cmdValid = 1'b0;
    end
    n.drivePos = playing && pwm;
    n.driveNeg = playing && !pwm;
    if (startCond) begin
      n.state = ST_RECV;
      n.bitCnt = '0;
      n.byteIdx = '0;
      n.txIdx = 1'b0;
      n.sdaOe = 1'b0;
      n.sclOe = 1'b0;
    end else if (stopCond) begin
      n.state = ST_IDLE;
      n.sdaOe = 1'b0;
      n.sclOe = 1'b0;
    end else begin
      unique case (r.state)
        ST_IDLE, ST_WAITSTOP: begin
          n.sdaOe = 1'b0;
        end
        ST_RECV: begin
          if (sclRise && r.bitCnt != FULL_BYTE) begin
            n.shift = {r.shift[6:0], n.sdaF};
            n.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall && r.bitCnt == FULL_BYTE) begin
            if (r.byteIdx == 2'h0) begin
              // general call and ten-bit headers never equal our address
              if (r.shift[7:1] == SLAVE_ADDR) begin
                n.isRead = r.shift[0];
                n.sdaOe = 1'b1;
                n.state = ST_ACK;
              end else begin
                n.state = ST_WAITSTOP;
              end
            end else if (r.byteIdx == 2'h1) begin
              n.cmd0 = r.shift;
              n.sdaOe = 1'b1;
              n.state = ST_ACK;
            end else if (r.byteIdx == CMD_LAST_BYTE) begin
              n.cmd1 = r.shift;
              n.sdaOe = 1'b1;
              n.state = ST_ACK;
            end else begin
              n.state = ST_WAITSTOP;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            n.sdaOe = 1'b0;
            n.byteIdx = r.byteIdx + 2'h1;
            n.bitCnt = '0;
            if (r.byteIdx == 2'h0 && r.isRead) begin
              n.shift = rev_byte(1'b0);
              n.sdaOe = !REVISION[15];
              n.state = ST_SEND;
            end else if (r.byteIdx == CMD_LAST_BYTE) begin
              // hold scl low until the player has taken the command or the stretch time-out expires
              n.cmdValid = 1'b1;
              n.sclOe = 1'b1;
              n.tmo = '0;
              n.state = ST_STRETCH;
            end else begin
              n.state = ST_RECV;
            end
          end
        end
        ST_STRETCH: begin
          n.tmo = r.tmo + 1'b1;
          if (!r.cmdValid) begin
            n.sclOe = 1'b0;
            n.state = ST_RECV;
          end else if (r.tmo == TMO_LAST) begin
            n.sclOe = 1'b0;
            n.cmdValid = 1'b0;
            n.state = ST_IDLE;
          end
        end
        ST_SEND: begin
          if (sclFall) begin
            if (r.bitCnt == LAST_BIT) begin
              n.sdaOe = 1'b0;
              n.state = ST_MACK;
            end else begin
              n.bitCnt = r.bitCnt + 4'h1;
              n.shift = {r.shift[6:0], 1'b0};
              n.sdaOe = !r.shift[6];
            end
          end
        end
        ST_MACK: begin
          if (sclRise) begin
            if (n.sdaF) begin
              n.state = ST_WAITSTOP;
            end else begin
              n.txIdx = ~r.txIdx;
            end
          end else if (sclFall) begin
            n.shift = txNext;
            n.sdaOe = !txNext[7];
            n.bitCnt = '0;
            n.state = ST_SEND;
          end
        end
        default: begin
          n.state = ST_IDLE;
          n.sdaOe = 1'b0;
          n.sclOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // open-drain pins only ever pull low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = r.sclOe;
  assign sdaOe = r.sdaOe;
  assign driveOutPos = r.drivePos;
  assign driveOutNeg = r.driveNeg;
endmodule : haptic_effect_pwm_controller

// ===== testbench/haptic_monitor.sv
// pin-level checks of the haptic controller
// assumes one clock domain; sclIn and sdaIn are resolved wire levels
module haptic_monitor #(
  parameter int STRETCH_TIMEOUT = haptic_pkg::STRETCH_TIMEOUT_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic driveOutPos,
  input wire logic driveOutNeg
);
  int stretchCnt;
  logic cmdSeen;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stretchCnt <= 0;
      cmdSeen <= 1'b0;
    end else begin
      stretchCnt <= sclOe ? stretchCnt + 1 : 0;
      cmdSeen <= cmdSeen || sclOe;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  drive_excl_a: assert property (!(driveOutPos && driveOutNeg))
    else $error("both drives high");
  scl_pull_only_a: assert property (sclOe |-> sclOut == 1'b0)
    else $error("scl driven high");
  sda_pull_only_a: assert property (sdaOe |-> sdaOut == 1'b0)
    else $error("sda driven high");
  sda_hold_a: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("sda changed while scl high");
  ack_after_fall_a: assert property ($rose(sdaOe) |-> !sclIn && !$past(sclIn, 3))
    else $error("sda driven before scl fall");
  stretch_limit_a: assert property (sclOe |-> stretchCnt <= STRETCH_TIMEOUT)
    else $error("stretch beyond time-out");
  stretch_low_a: assert property ($rose(sclOe) |-> !$past(sclIn, 2))
    else $error("stretch began with scl high");
  drive_cmd_a: assert property (driveOutPos || driveOutNeg |-> cmdSeen)
    else $error("drive active without command");
endmodule : haptic_monitor

bind haptic_effect_pwm_controller haptic_monitor #(.STRETCH_TIMEOUT(STRETCH_TIMEOUT)) mon (
  .clock(clock), .rstn(rstn), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .driveOutPos(driveOutPos), .driveOutNeg(driveOutNeg));

// ===== testbench/i2c_master_model.sv
// bit-banged i2c master pulling scl and sda low through open drains
// assumes the bench resolves both wires with pull-ups
module i2c_master_model (
  input wire logic clock,
  input wire logic sclLine,
  input wire logic sdaLine,
  output logic sclPull,
  output logic sdaPull
);
  timeunit 1ns;
  timeprecision 1ps;
  int halfTicks = 7;
  int stallCount = 0;
  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask : ticks
  // master makes every scl edge; waits out a stretch
  task automatic sclRise();
    int guard;
    guard = 0;
    sclPull <= 1'b0;
    ticks(1);
    while (!sclLine && guard < 4000) begin
      guard++;
      ticks(1);
    end
    stallCount += (guard > 4) ? 1 : 0;
    ticks(halfTicks - 1);
  endtask : sclRise
  task automatic xferBit(input logic b, output logic r);
    sdaPull <= !b;
    ticks(halfTicks);
    sclRise();
    r = sdaLine;
    sclPull <= 1'b1;
    ticks(2);
    // high 7 plus low 9 clocks keeps scl at 80 ns
  endtask : xferBit
  task automatic start();
    sdaPull <= 1'b1;
    ticks(halfTicks);
    sclPull <= 1'b1;
    ticks(2);
  endtask : start
  task automatic stop();
    sdaPull <= 1'b1;
    ticks(halfTicks);
    sclRise();
    sdaPull <= 1'b0;
    ticks(halfTicks);
  endtask : stop
  task automatic byteTx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xferBit(d[i], r);
    end
    xferBit(1'b1, r);
    ack = !r;
  endtask : byteTx
  task automatic byteRx(input logic masterAck, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xferBit(1'b1, d[i]);
    end
    xferBit(!masterAck, r);
  endtask : byteRx
endmodule : i2c_master_model

// ===== testbench/haptic_effect_pwm_controller_bench.sv
// self-checking bench of the haptic controller with an i2c master model
// assumes small HALF_CYCLES and STRETCH_TIMEOUT to keep the run short
module haptic_effect_pwm_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] REV = 16'hA5C3;
  logic clock;
  logic rstn;
  logic sclOe;
  logic sdaOe;
  logic pos;
  logic neg;
  logic sclPull;
  logic sdaPull;
  wire sclLine = !(sclOe || sclPull);
  wire sdaLine = !(sdaOe || sdaPull);
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  haptic_effect_pwm_controller #(.HALF_CYCLES(64), .STRETCH_TIMEOUT(2048), .REVISION(REV)) dut (
    .clock(clock), .rstn(rstn), .sclIn(sclLine), .sclOut(), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(),
    .sdaOe(sdaOe), .driveOutPos(pos), .driveOutNeg(neg));
  i2c_master_model master (.clock(clock), .sclLine(sclLine), .sdaLine(sdaLine), .sclPull(sclPull),
    .sdaPull(sdaPull));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic sendCmd(input logic [6:0] a, input logic [7:0] c0, input logic [7:0] c1, output logic [2:0] acks);
    master.start();
    master.byteTx({a, 1'b0}, acks[2]);
    master.byteTx(c0, acks[1]);
    master.byteTx(c1, acks[0]);
    master.stop();
  endtask : sendCmd
  // cycles until drives wake, then cycles until both idle again
  task automatic measure(input int limit, output int wakeWait, output int playLen);
    wakeWait = 0;
    playLen = 0;
    while (!pos && !neg && wakeWait < limit) begin
      @(negedge clock);
      wakeWait++;
    end
    while ((pos || neg) && playLen < 20000) begin
      check({15'h0, neg}, {15'h0, !pos});
      @(negedge clock);
      playLen++;
    end
  endtask : measure
  task automatic testPlay();
    logic [2:0] acks;
    int w;
    int n;
    master.stallCount = 0;
    sendCmd(7'h10, 8'h01, 8'h05, acks);
    check({13'h0, acks}, 16'h0007);
    check({15'h0, master.stallCount > 0}, 16'h0001);
    measure(2000, w, n);
    check({15'h0, n > 2400 && n < 3600}, 16'h0001);
    measure(2000, w, n);
    check(w[15:0], 16'd2000);
  endtask : testPlay
  task automatic testAbort();
    logic [2:0] acks;
    int w;
    int n;
    sendCmd(7'h10, 8'h01, 8'h0A, acks);
    @(negedge clock);
    check({15'h0, pos || neg}, 16'h0001);
    sendCmd(7'h10, 8'h02, 8'h00, acks);
    check({13'h0, acks}, 16'h0007);
    measure(1, w, n);
    check({15'h0, n < 1200}, 16'h0001);
  endtask : testAbort
  task automatic testIgnored(input logic [6:0] a, input logic [7:0] c0, input logic [7:0] c1, input logic [2:0] exp);
    logic [2:0] acks;
    int w;
    int n;
    sendCmd(a, c0, c1, acks);
    check({13'h0, acks}, {13'h0, exp});
    measure(1500, w, n);
    check(w[15:0], 16'd1500);
  endtask : testIgnored
  task automatic testRevision();
    logic [2:0] acks;
    logic a;
    logic [7:0] hi;
    logic [7:0] lo;
    master.halfTicks = 24;
    sendCmd(7'h10, 8'h03, 8'h00, acks);
    master.start();
    master.byteTx(8'h21, a);
    master.byteRx(1'b1, hi);
    master.byteRx(1'b0, lo);
    master.stop();
    check({12'h0, acks, a}, 16'h000F);
    check({hi, lo}, REV);
    master.halfTicks = 7;
  endtask : testRevision
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    rstn = 1'b0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (10) @(posedge clock);
    check({12'h0, pos, neg, sclOe, sdaOe}, 16'h0000);
    testPlay();
    testAbort();
    testIgnored(7'h11, 8'h01, 8'h05, 3'b000);
    testIgnored(7'h00, 8'h01, 8'h05, 3'b000);
    testIgnored(7'h78, 8'h01, 8'h05, 3'b000);
    testIgnored(7'h10, 8'h01, 8'h0E, 3'b111);
    testIgnored(7'h10, 8'h7F, 8'h00, 3'b111);
    testRevision();
    complete_run();
  end
endmodule : haptic_effect_pwm_controller_bench
